// File: src/msrep_pkg.sv
package msrep_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;
    localparam int QIDX_W = 6;

    localparam logic [ADDR_W-1:0] IDX_MASK2 = 5'h1D;
    localparam logic [ADDR_W-1:0] IDX_STAT2 = 5'h1E;
    localparam logic [ADDR_W-1:0] IDX_QPTR  = 5'h1F;
    localparam logic [7:0]        HOST_OFF_MASK2 = 8'h74;
    localparam logic [7:0]        HOST_OFF_STAT2 = 8'h78;
    localparam logic [7:0]        HOST_OFF_QPTR  = 8'h7C;

    localparam int B_MASTER     = 15;
    localparam int B_OPC_PAR    = 14;
    localparam int B_ILL_MSG    = 13;
    localparam int B_Q_ROLL     = 12;
    localparam int B_CSP_ERR    = 11;
    localparam int B_TRAP       = 10;
    localparam int B_RT_CMD_HF  = 9;
    localparam int B_RT_CBUF_HF = 8;
    localparam int B_MT_CMD_HF  = 7;
    localparam int B_MT_DATA_HF = 6;
    localparam int B_PROG_LO    = 2;
    localparam int B_BIT_DONE   = 1;
    localparam int B_CHAIN      = 0;

    localparam logic [DATA_W-1:0] EVENT_BITS = 16'h7FFE;
    localparam logic [DATA_W-1:0] MASK2_RST  = 16'h0000;
    localparam logic [DATA_W-1:0] STAT2_RST  = 16'h0000;
    localparam logic [DATA_W-1:0] QPTR_RST   = 16'h0000;
    localparam logic [QIDX_W-1:0] QIDX_LAST  = 6'h3F;

    localparam int CW_RTA_LSB = 11;
    localparam int CW_TR      = 10;
    localparam int CW_SA_LSB  = 5;
    localparam int MON_GAP_LSB = 8;
    localparam int QE_MSG     = 0;

    typedef enum logic [1:0] {
        MSREP_BC = 2'b00,
        MSREP_RT = 2'b01,
        MSREP_MT = 2'b10
    } msrep_mode_e;

    typedef enum logic [1:0] {
        MSREP_BC_BSW = 2'b00,
        MSREP_RT_BSW = 2'b01,
        MSREP_CMD    = 2'b10,
        MSREP_MON_ID = 2'b11
    } msrep_kind_e;

endpackage

// File: src/msrep_word_pack.sv
`timescale 1ns/1ps
module msrep_word_pack
    import msrep_pkg::*;
(
    input  msrep_pkg::msrep_kind_e kind,
    input  wire logic        end_of_message,
    input  wire logic        start_of_message,
    input  wire logic        chan_b,
    input  wire logic        error_flag,
    input  wire logic        format_error,
    input  wire logic        no_response,
    input  wire logic        loop_fail,
    input  wire logic        word_cnt_err,
    input  wire logic        invalid_word,
    input  wire logic        sync_err,
    input  wire logic        bc_status_set,
    input  wire logic        bc_masked_set,
    input  wire logic [1:0]  bc_retry,
    input  wire logic        bc_good_block,
    input  wire logic        bc_wrong_addr,
    input  wire logic        rt_rt_format,
    input  wire logic        rt_stack_roll,
    input  wire logic        rt_illegal_word,
    input  wire logic        rt_gap_err,
    input  wire logic        rt_cmd2_err,
    input  wire logic        rt_cmd_err,
    input  wire logic [4:0]  cw_rt_addr,
    input  wire logic        cw_tx,
    input  wire logic [4:0]  cw_subaddr,
    input  wire logic [4:0]  cw_count,
    input  wire logic [7:0]  mon_gap,
    input  wire logic [7:0]  mon_flags,
    output logic      [15:0] word
);
    always_comb begin
        unique case (kind)
            MSREP_BC_BSW: word = {end_of_message, start_of_message, chan_b, error_flag,
                                  bc_status_set, format_error, no_response, loop_fail,
                                  bc_masked_set, bc_retry, bc_good_block,
                                  bc_wrong_addr, word_cnt_err, sync_err, invalid_word};
            MSREP_RT_BSW: word = {end_of_message, start_of_message, chan_b, error_flag,
                                  rt_rt_format, format_error, no_response, loop_fail,
                                  rt_stack_roll, rt_illegal_word, word_cnt_err, sync_err,
                                  invalid_word, rt_gap_err, rt_cmd2_err, rt_cmd_err};
            MSREP_CMD:    word = {cw_rt_addr, cw_tx, cw_subaddr, cw_count};
            MSREP_MON_ID: word = {mon_gap, mon_flags};
        endcase
    end
endmodule

// File: src/msrep_status_bank.sv
`timescale 1ns/1ps
module msrep_status_bank
    import msrep_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  msrep_pkg::msrep_mode_e    mode,
    input  wire logic [msrep_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [15:0]          reg_wdata,
    output logic      [15:0]          reg_rdata,
    output logic                      reg_rd_valid,
    output logic                      master_irq,
    input  wire logic                 ev_opcode_parity,
    input  wire logic                 ev_illegal_cmd,
    input  wire logic                 ev_msg_received,
    input  wire logic                 ev_call_stack_err,
    input  wire logic                 ev_trap_opcode,
    input  wire logic                 ev_rt_cmd_half,
    input  wire logic                 ev_rt_cbuf_half,
    input  wire logic                 ev_mt_cmd_half,
    input  wire logic                 ev_mt_data_half,
    input  wire logic [3:0]           ev_program_req,
    input  wire logic                 ev_bit_done,
    input  wire logic                 chain_in,
    input  wire logic                 q_push,
    input  wire logic [15:0]          q_data,
    input  wire logic                 q_msg_event,
    input  wire logic                 word_req,
    input  msrep_pkg::msrep_kind_e    word_kind,
    input  wire logic [15:0]          word_addr,
    output logic                      word_ack,
    input  wire logic                 end_of_message,
    input  wire logic                 start_of_message,
    input  wire logic                 chan_b,
    input  wire logic                 error_flag,
    input  wire logic                 format_error,
    input  wire logic                 no_response,
    input  wire logic                 loop_fail,
    input  wire logic                 word_cnt_err,
    input  wire logic                 invalid_word,
    input  wire logic                 sync_err,
    input  wire logic                 bc_status_set,
    input  wire logic                 bc_masked_set,
    input  wire logic [1:0]           bc_retry,
    input  wire logic                 bc_good_block,
    input  wire logic                 bc_wrong_addr,
    input  wire logic                 rt_rt_format,
    input  wire logic                 rt_stack_roll,
    input  wire logic                 rt_illegal_word,
    input  wire logic                 rt_gap_err,
    input  wire logic                 rt_cmd2_err,
    input  wire logic                 rt_cmd_err,
    input  wire logic [4:0]           cw_rt_addr,
    input  wire logic                 cw_tx,
    input  wire logic [4:0]           cw_subaddr,
    input  wire logic [4:0]           cw_count,
    input  wire logic [7:0]           mon_gap,
    input  wire logic [7:0]           mon_flags,
    output logic                      mem_we,
    output logic      [15:0]          mem_addr,
    output logic      [15:0]          mem_wdata
);
    import msrep_pkg::*;

    logic [15:0]       status_reg;
    logic [15:0]       status_next;
    logic [15:0]       mask_reg;
    logic [15:0]       mask_next;
    logic              master_reg;
    logic              master_next;
    logic [9:0]        qbase_reg;
    logic [9:0]        qbase_next;
    logic [QIDX_W-1:0] qidx_reg;
    logic [QIDX_W-1:0] qidx_next;
    logic [15:0]       rdata_reg;
    logic [15:0]       rdata_next;
    logic              rvalid_reg;
    logic              rvalid_next;
    logic              ack_reg;
    logic              ack_next;
    logic              we_reg;
    logic              we_next;
    logic [15:0]       maddr_reg;
    logic [15:0]       maddr_next;
    logic [15:0]       mdata_reg;
    logic [15:0]       mdata_next;
    logic [15:0]       set_vec;
    logic [15:0]       clr_vec;
    logic [15:0]       packed_word;
    logic [15:0]       sum_next;
    logic              qptr_wr;
    logic              q_wrap;
    logic              is_bc;

    function automatic logic [15:0] summary(input logic [15:0] st, input logic [15:0] mk, input logic ch);
        logic [15:0] w;
        w = st & EVENT_BITS;
        w[B_MASTER] = |(st & mk & EVENT_BITS);
        w[B_CHAIN]  = ch;
        return w;
    endfunction

    msrep_word_pack u_pack (
        .kind             (word_kind),
        .end_of_message   (end_of_message),
        .start_of_message (start_of_message),
        .chan_b           (chan_b),
        .error_flag       (error_flag),
        .format_error     (format_error),
        .no_response      (no_response),
        .loop_fail        (loop_fail),
        .word_cnt_err     (word_cnt_err),
        .invalid_word     (invalid_word),
        .sync_err         (sync_err),
        .bc_status_set    (bc_status_set),
        .bc_masked_set    (bc_masked_set),
        .bc_retry         (bc_retry),
        .bc_good_block    (bc_good_block),
        .bc_wrong_addr    (bc_wrong_addr),
        .rt_rt_format     (rt_rt_format),
        .rt_stack_roll    (rt_stack_roll),
        .rt_illegal_word  (rt_illegal_word),
        .rt_gap_err       (rt_gap_err),
        .rt_cmd2_err      (rt_cmd2_err),
        .rt_cmd_err       (rt_cmd_err),
        .cw_rt_addr       (cw_rt_addr),
        .cw_tx            (cw_tx),
        .cw_subaddr       (cw_subaddr),
        .cw_count         (cw_count),
        .mon_gap          (mon_gap),
        .mon_flags        (mon_flags),
        .word             (packed_word)
    );

    always_comb begin
        is_bc   = (mode == MSREP_BC);
        qptr_wr = reg_wr && (reg_addr == IDX_QPTR);
        q_wrap  = q_push && !qptr_wr && (qidx_reg == QIDX_LAST);
        set_vec = 16'h0000;
        set_vec[B_OPC_PAR]  = is_bc && ev_opcode_parity;
        set_vec[B_TRAP]     = is_bc && ev_trap_opcode;
        set_vec[B_PROG_LO+3:B_PROG_LO] = is_bc ? ev_program_req : 4'h0;
        set_vec[B_CSP_ERR]  = is_bc && ev_call_stack_err;
        set_vec[B_ILL_MSG]  = ((mode == MSREP_RT) && ev_illegal_cmd) ||
                              ((mode == MSREP_MT) && ev_msg_received);
        set_vec[B_Q_ROLL]   = q_wrap;
        set_vec[B_RT_CMD_HF]  = ev_rt_cmd_half;
        set_vec[B_RT_CBUF_HF] = ev_rt_cbuf_half;
        set_vec[B_MT_CMD_HF]  = ev_mt_cmd_half;
        set_vec[B_MT_DATA_HF] = ev_mt_data_half;
        set_vec[B_BIT_DONE]   = ev_bit_done;
        clr_vec = (reg_rd && (reg_addr == IDX_STAT2)) ? EVENT_BITS : 16'h0000;
        status_next = ((status_reg & ~clr_vec) | set_vec) & EVENT_BITS;
        mask_next = (reg_wr && (reg_addr == IDX_MASK2)) ? reg_wdata : mask_reg;
        sum_next = summary(status_next, mask_next, chain_in);
        master_next = sum_next[B_MASTER];
    end

    always_comb begin
        qbase_next = qbase_reg;
        qidx_next  = qidx_reg;
        we_next    = 1'b0;
        maddr_next = maddr_reg;
        mdata_next = mdata_reg;
        ack_next   = 1'b0;
        if (qptr_wr) begin
            qbase_next = reg_wdata[15:QIDX_W];
            qidx_next  = reg_wdata[QIDX_W-1:0];
        end else if (q_push) begin
            qidx_next = qidx_reg + 6'h01;
        end
        if (q_push) begin
            we_next    = 1'b1;
            maddr_next = {qbase_reg, qidx_reg};
            mdata_next = q_data;
            if (!is_bc) begin
                mdata_next[QE_MSG] = q_msg_event;
            end
        end else if (word_req && !ack_reg) begin
            we_next    = 1'b1;
            maddr_next = word_addr;
            mdata_next = packed_word;
            ack_next   = 1'b1;
        end
    end

    always_comb begin
        rvalid_next = reg_rd;
        rdata_next  = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                IDX_MASK2: rdata_next = mask_reg;
                IDX_STAT2: rdata_next = summary(status_reg, mask_reg, chain_in);
                IDX_QPTR:  rdata_next = {qbase_reg, qidx_reg};
                default:   rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            status_reg <= STAT2_RST;
            mask_reg   <= MASK2_RST;
            master_reg <= 1'b0;
            qbase_reg  <= QPTR_RST[15:QIDX_W];
            qidx_reg   <= QPTR_RST[QIDX_W-1:0];
            rdata_reg  <= 16'h0000;
            rvalid_reg <= 1'b0;
            ack_reg    <= 1'b0;
            we_reg     <= 1'b0;
            maddr_reg  <= 16'h0000;
            mdata_reg  <= 16'h0000;
        end else begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
            master_reg <= master_next;
            qbase_reg  <= qbase_next;
            qidx_reg   <= qidx_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            ack_reg    <= ack_next;
            we_reg     <= we_next;
            maddr_reg  <= maddr_next;
            mdata_reg  <= mdata_next;
        end
    end

    assign reg_rdata    = rdata_reg;
    assign reg_rd_valid = rvalid_reg;
    assign master_irq   = master_reg;
    assign word_ack     = ack_reg;
    assign mem_we       = we_reg;
    assign mem_addr     = maddr_reg;
    assign mem_wdata    = mdata_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_master;
        master_reg == |(status_reg & mask_reg & EVENT_BITS);
    endproperty
    a_master: assert property (p_master) else $error("master bit disagrees with enabled events");

    property p_stat_read;
        reg_rd && reg_addr == IDX_STAT2 |=> reg_rd_valid && reg_rdata[B_MASTER] == $past(master_reg)
            && reg_rdata[B_CHAIN] == $past(chain_in);
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status read data wrong");

    property p_q_roll;
        q_push && !qptr_wr && qidx_reg == QIDX_LAST |=> status_reg[B_Q_ROLL] && qidx_reg == 6'h00;
    endproperty
    a_q_roll: assert property (p_q_roll) else $error("queue wrap not reported");

    property p_ill_rt;
        mode == MSREP_RT && ev_illegal_cmd |=> status_reg[B_ILL_MSG];
    endproperty
    a_ill_rt: assert property (p_ill_rt) else $error("illegal command not flagged");

    property p_trap_gate;
        mode != MSREP_BC && !status_reg[B_TRAP] |=> !status_reg[B_TRAP];
    endproperty
    a_trap_gate: assert property (p_trap_gate) else $error("trap flagged outside controller mode");

    property p_csp;
        mode == MSREP_BC && ev_call_stack_err |=> status_reg[B_CSP_ERR];
    endproperty
    a_csp: assert property (p_csp) else $error("call stack error not flagged");

    property p_set_wins;
        ev_bit_done && reg_rd && reg_addr == IDX_STAT2 |=> status_reg[B_BIT_DONE];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to read clear");

    property p_q_adv;
        q_push && !qptr_wr |=> qidx_reg == QIDX_W'($past(qidx_reg) + 6'h01) && qbase_reg == $past(qbase_reg);
    endproperty
    a_q_adv: assert property (p_q_adv) else $error("queue index or base wrong after push");

    property p_q_entry;
        q_push && mode != MSREP_BC |=> mem_we && mem_wdata[QE_MSG] == $past(q_msg_event)
            && mem_addr == {$past(qbase_reg), $past(qidx_reg)};
    endproperty
    a_q_entry: assert property (p_q_entry) else $error("queue entry write wrong");

    property p_cmd_word;
        word_req && !word_ack && !q_push && word_kind == MSREP_CMD |=> mem_we && word_ack
            && mem_wdata[15:CW_RTA_LSB] == $past(cw_rt_addr) && mem_wdata[CW_TR] == $past(cw_tx);
    endproperty
    a_cmd_word: assert property (p_cmd_word) else $error("command word write wrong");

    c_wrap:   cover property (q_push && qidx_reg == QIDX_LAST);
    c_word:   cover property (word_ack && mem_we);
    c_master: cover property (reg_rd_valid && reg_rdata[B_MASTER]);
endmodule

// File: tb/msrep_ram_model.sv
`timescale 1ns/1ps
module msrep_ram_model (
    input  wire logic        clock,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata
);
    // Shared memory; device words land here as plain data
    logic [15:0] ram [0:65535];

    always @(posedge clock) begin
        if (mem_we === 1'b1) begin
            ram[mem_addr] <= mem_wdata;
        end
    end
endmodule

// File: tb/tb_msrep_status_bank.sv
`timescale 1ns/1ps
module tb_msrep_status_bank;
    import msrep_pkg::*;
    logic        clock, rst_n, reg_wr, reg_rd, reg_rd_valid, master_irq, chain_in;
    logic        q_push, q_msg_event, word_req, word_ack, mem_we, ch;
    msrep_mode_e mode;
    msrep_kind_e word_kind;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q_data, word_addr, mem_addr, mem_wdata, ev, m, d, qd;
    logic [63:0] f;
    logic [9:0]  base;
    int          fails, samples_checked, eb;
    integer      seed = 32'hb1cd06b5;

    msrep_status_bank u_msrep_status_bank (
        .clock(clock), .rst_n(rst_n), .mode(mode), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .master_irq(master_irq), .ev_opcode_parity(ev[14]), .ev_illegal_cmd(ev[13]),
        .ev_msg_received(ev[0]), .ev_call_stack_err(ev[11]), .ev_trap_opcode(ev[10]),
        .ev_rt_cmd_half(ev[9]), .ev_rt_cbuf_half(ev[8]), .ev_mt_cmd_half(ev[7]),
        .ev_mt_data_half(ev[6]), .ev_program_req(ev[5:2]), .ev_bit_done(ev[1]), .chain_in(chain_in),
        .q_push(q_push), .q_data(q_data), .q_msg_event(q_msg_event), .word_req(word_req),
        .word_kind(word_kind), .word_addr(word_addr), .word_ack(word_ack),
        .end_of_message(f[0]), .start_of_message(f[1]), .chan_b(f[2]), .error_flag(f[3]),
        .format_error(f[4]), .no_response(f[5]), .loop_fail(f[6]), .word_cnt_err(f[7]),
        .invalid_word(f[8]), .sync_err(f[9]), .bc_status_set(f[10]), .bc_masked_set(f[11]),
        .bc_retry(f[13:12]), .bc_good_block(f[14]), .bc_wrong_addr(f[15]), .rt_rt_format(f[16]),
        .rt_stack_roll(f[17]), .rt_illegal_word(f[18]), .rt_gap_err(f[19]), .rt_cmd2_err(f[20]),
        .rt_cmd_err(f[21]), .cw_rt_addr(f[26:22]), .cw_tx(f[27]), .cw_subaddr(f[32:28]),
        .cw_count(f[37:33]), .mon_gap(f[45:38]), .mon_flags(f[53:46]),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata)
    );

    msrep_ram_model u_msrep_ram_model (
        .clock(clock), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata)
    );

    function automatic logic [15:0] pack(input msrep_kind_e k, input logic [63:0] v);
        case (k)
            MSREP_BC_BSW: return {v[0], v[1], v[2], v[3], v[10], v[4], v[5], v[6],
                                  v[11], v[13:12], v[14], v[15], v[7], v[9], v[8]};
            MSREP_RT_BSW: return {v[0], v[1], v[2], v[3], v[16], v[4], v[5], v[6],
                                  v[17], v[18], v[7], v[9], v[8], v[19], v[20], v[21]};
            MSREP_CMD:    return {v[26:22], v[27], v[32:28], v[37:33]};
            default:      return {v[45:38], v[53:46]};
        endcase
    endfunction

    function automatic msrep_mode_e mode_for(input int b);
        if (b == 0) return MSREP_MT;
        if (b == 13) return MSREP_RT;
        if (b == 14 || b == 11 || b == 10 || (b >= 2 && b <= 5)) return MSREP_BC;
        return msrep_mode_e'(2'($unsigned($random(seed)) % 3));
    endfunction

    function automatic logic [15:0] exp_stat(input int b, input logic [15:0] mk, input logic c);
        logic [15:0] s;
        s = 16'h0001 << b;
        s[B_MASTER] = |(s & mk & EVENT_BITS);
        s[B_CHAIN] = c;
        return s;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk({15'h0000, reg_rd_valid}, 16'h0001);
        v = reg_rdata;
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        tally_and_finish();
    end

    initial begin
        {rst_n, reg_wr, reg_rd, chain_in, q_push, q_msg_event, word_req} = '0;
        {reg_addr, reg_wdata, q_data, word_addr, ev, f} = '0;
        mode = MSREP_BC;
        word_kind = MSREP_BC_BSW;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values, read-only status, unmapped index, mask readback
        rd(IDX_MASK2, d);
        chk(d, MASK2_RST);
        rd(IDX_STAT2, d);
        chk(d, STAT2_RST);
        rd(IDX_QPTR, d);
        chk(d, QPTR_RST);
        rd(5'h00, d);
        chk(d, 16'h0000);
        wr(IDX_STAT2, 16'hFFFF);
        rd(IDX_STAT2, d);
        chk(d, 16'h0000);
        m = 16'($random(seed)) & EVENT_BITS;
        wr(IDX_MASK2, m);
        rd(IDX_MASK2, d);
        chk(d, m);
        // Every event source except queue rollover, with random mask (zero mask for bit-done) and chain level
        for (int b = 0; b < 15; b++) begin
            if (b == 12) continue;
            eb = (b == 0) ? 13 : b;
            m = (b == 1) ? 16'h0000 : 16'($random(seed)) & EVENT_BITS;
            ch = 1'($random(seed));
            wr(IDX_MASK2, m);
            @(posedge clock);
            mode <= mode_for(b);
            chain_in <= ch;
            ev <= 16'h0001 << b;
            @(posedge clock);
            ev <= 16'h0000;
            repeat (3) @(posedge clock);
            #1;
            chk({15'h0000, master_irq}, {15'h0000, m[eb]});
            rd(IDX_STAT2, d);
            chk(d, exp_stat(eb, m, ch));
            rd(IDX_STAT2, d);
            chk(d, {15'h0000, ch});
        end
        // Controller events ignored outside controller mode and the reverse
        wr(IDX_MASK2, 16'h0000);
        @(posedge clock);
        mode <= MSREP_RT;
        ev <= 16'h4000;
        @(posedge clock);
        mode <= MSREP_BC;
        ev <= 16'h2000;
        @(posedge clock);
        ev <= 16'h0000;
        rd(IDX_STAT2, d);
        chk(d, {15'h0000, ch});
        // Event in the same cycle as a clearing read survives it
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= IDX_STAT2;
        ev <= 16'h0002;
        @(posedge clock);
        reg_rd <= 1'b0;
        ev <= 16'h0000;
        rd(IDX_STAT2, d);
        chk(d, {14'h0000, 1'b1, ch});
        // Queue pointer: fixed base, index wraps, rollover flagged
        base = 10'($random(seed));
        @(posedge clock);
        mode <= MSREP_RT;
        wr(IDX_QPTR, {base, 6'h3E});
        for (int i = 0; i < 4; i++) begin
            qd = 16'($random(seed));
            @(posedge clock);
            q_push <= 1'b1;
            q_data <= qd;
            q_msg_event <= i[0];
            if (i == 3) mode <= MSREP_BC;
            @(posedge clock);
            q_push <= 1'b0;
            #1;
            chk({15'h0000, mem_we}, 16'h0001);
            chk(mem_addr, {base, 6'(6'h3E + i)});
            chk(mem_wdata, (i == 3) ? qd : {qd[15:1], i[0]});
        end
        rd(IDX_STAT2, d);
        chk(d, {3'b000, 1'b1, 11'h000, ch});
        rd(IDX_QPTR, d);
        chk(d, {base, 6'h02});
        // Words written into shared memory, every kind, all-ones corner first
        for (int i = 0; i < 12; i++) begin
            @(posedge clock);
            word_req <= 1'b1;
            word_kind <= msrep_kind_e'(i % 4);
            word_addr <= 16'($random(seed));
            f <= (i < 4) ? '1 : {$random(seed), $random(seed)};
            for (int w = 0; w < 5; w++) begin
                @(posedge clock);
                #1;
                if (word_ack === 1'b1) break;
            end
            chk({15'h0000, word_ack}, 16'h0001);
            @(posedge clock);
            word_req <= 1'b0;
            #1;
            chk(u_msrep_ram_model.ram[word_addr], pack(word_kind, f));
        end
        tally_and_finish();
    end
endmodule
